/* File: bench/pin_receiver.sv */
// receiving circuit on one encoded pin: measures the last high and low runs
module pin_receiver (
    input wire logic clock, // master clock
    input wire logic rst, // async reset, active high
    input wire logic pin, // encoded pin level
    output int high_len, // clocks of the last complete high run
    output int low_len, // clocks of the last complete low run
    output int edges // level changes seen since reset
);
    timeunit 1ns;
    timeprecision 1ps;
    int run;
    logic prev;
    // ------------------------------------------------------------
    // run length capture
    // ------------------------------------------------------------
    // a run is only reported once it ends, so a stale value survives a restart
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            high_len <= 0;
            low_len <= 0;
            edges <= 0;
            run <= 0;
            prev <= 1'b0;
        end else begin
            prev <= pin;
            if (pin !== prev) begin
                if (prev) high_len <= run;
                else low_len <= run;
                run <= 1;
                edges <= edges + 1;
            end else begin
                run <= run + 1;
            end
        end
    end
endmodule

/* File: bench/tb.sv */
// self-checking bench of the level pwm encoder
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_enc_pkg::*;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, pin2_out, pin3_out;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [APB_DATA_W-1:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic err;
    int fail_count = 0, tests_run = 0, cycles = 0, h2, l2, e2, h3, l3, e3;
    // ------------------------------------------------------------
    // design and receivers
    // ------------------------------------------------------------
    pwm_level_encoder dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pin2_out(pin2_out), .pin3_out(pin3_out));
    pin_receiver rx2_u (.clock(clock), .rst(rst), .pin(pin2_out), .high_len(h2), .low_len(l2), .edges(e2));
    pin_receiver rx3_u (.clock(clock), .rst(rst), .pin(pin3_out), .high_len(h3), .low_len(l3), .edges(e3));
    always #4 clock = ~clock;
    // hang guard: the whole sequence needs roughly 19k clocks
    always @(posedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    // ------------------------------------------------------------
    // apb master: request held until pready is seen at a rising edge
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // pready is taken at the rising edge; only the hang guard ends a wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wave_chk(input string name, input int pin, input int hi, input int lo);
        repeat (3 * (hi + lo) + 8) @(posedge clock);
        chk(name, hi, pin == 2 ? h2 : h3);
        chk(name, lo, pin == 2 ? l2 : l3);
    endtask
    task automatic static_chk(input string name, input logic lvl);
        int e0;
        repeat (6) @(posedge clock);
        e0 = e2;
        repeat (300) @(posedge clock);
        chk(name, e0, e2);
        chk(name, lvl, pin2_out);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs();
        apb(1'b0, ADDR_PIN2_HL, '0);
        chk("pin2 hl reset", 32'h0000_3F80, rd);
        apb(1'b0, ADDR_PIN3_LL, '0);
        chk("pin3 ll reset", 32'h0000_007F, rd);
        apb(1'b0, 12'h000, '0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test reset_regs done");
    endtask
    task automatic t_reg_rw();
        apb(1'b1, ADDR_PIN2_HL, 32'h0000_FFFF);
        apb(1'b0, ADDR_PIN2_HL, '0);
        chk("pin2 hl reserved", 32'h0000_3FFF, rd);
        apb(1'b1, ADDR_PIN3_LL, 32'h0000_C000);
        apb(1'b0, ADDR_PIN3_LL, '0);
        chk("pin3 ll rw", 32'h0000_C000, rd);
        $display("test reg_rw done");
    endtask
    task automatic t_wave_pin2();
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_PIN2_HL, (32'd2 << 7) | 32'd2);
        wave_chk("pin2 2/2 units", 2, 32, 32);
        apb(1'b1, ADDR_PIN2_HL, (32'd1 << 7) | 32'd3);
        for (int tb = 0; tb < 4; tb++) begin
            apb(1'b1, ADDR_CTRL, (tb << 2) | 1);
            wave_chk("pin2 time base", 2, 16 << (2 * tb), 48 << (2 * tb));
        end
        $display("test wave_pin2 done");
    endtask
    task automatic t_static_pin2();
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_PIN2_HL, 32'd5);
        static_chk("hc zero low", 1'b0);
        apb(1'b1, ADDR_PIN2_HL, 32'd5 << 7);
        static_chk("lc zero high", 1'b1);
        apb(1'b0, ADDR_STATUS, '0);
        chk("status static pins", 32'h0000_000D, rd);
        apb(1'b1, ADDR_PIN2_HL, 32'd0);
        static_chk("both zero low", 1'b0);
        apb(1'b1, ADDR_PIN2_HL, 32'd5 << 7);
        apb(1'b1, ADDR_CTRL, 32'h0);
        static_chk("level switch low", 1'b0);
        $display("test static_pin2 done");
    endtask
    task automatic t_pin3_low();
        apb(1'b1, ADDR_PIN3_LL, (32'd1 << 14) | (32'd2 << 7) | 32'd1);
        wave_chk("pin3 low level", 3, 128, 64);
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (4) @(posedge clock);
        chk("pin3 lh reset static high", 32'h1, {31'h0, pin3_out});
        apb(1'b1, ADDR_PIN3_HL, (32'd1 << 7) | 32'd1);
        wave_chk("pin3 high level", 3, 64, 64);
        $display("test pin3_low done");
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_reset_regs();
        t_reg_rw();
        t_wave_pin2();
        t_static_pin2();
        t_pin3_low();
        print_verdict();
    end
endmodule

/* File: design/pwm_level_encoder.sv */
// pwm level encoder for two output pins with an apb register slave
module pwm_level_encoder
    import pwm_enc_pkg::*;
(
    input wire logic clock, // master clock, 125 mhz
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [APB_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [APB_DATA_W-1:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic pready, // apb ready
    output logic [APB_DATA_W-1:0] prdata, // apb read data
    output logic pslverr, // apb error
    output logic pin2_out, // pin2 encoded level
    output logic pin3_out // pin3 encoded level
);
    logic [CFG_W-1:0] pin2_high_level_pwm_config;
    logic [CFG_W-1:0] pin3_low_level_pwm_config;
    logic [CFG_W-1:0] pin2_low_level_pwm_config;
    logic [CFG_W-1:0] pin3_high_level_pwm_config;
    logic [CTRL_W-1:0] level_ctrl;
    logic [APB_DATA_W-1:0] rd_value;
    logic rd_hit;
    logic wr_en;
    logic pin2_level;
    logic pin3_level;
    logic [TB_W-1:0] pin2_time_base_select;
    logic [TB_W-1:0] pin3_time_base_select;
    logic restart2;
    logic restart3;

    pwm_pair_if ch2();
    pwm_pair_if ch3();

    // merge of the two low byte lanes under strobe and writable mask
    function automatic logic [CFG_W-1:0] merge(input logic [CFG_W-1:0] old,
                                               input logic [APB_DATA_W-1:0] wd,
                                               input logic [3:0] strb,
                                               input logic [CFG_W-1:0] wmask);
        logic [CFG_W-1:0] m;
        m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old & ~m) | (wd[CFG_W-1:0] & m);
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------

    // a write lands only at the edge that completes the access phase
    assign wr_en = psel && penable && pready && pwrite;

    // read decode; unmapped addresses and status writes answer with an error
    always_comb begin
        rd_hit = 1'b1;
        rd_value = '0;
        case (paddr)
            ADDR_PIN2_HL: rd_value[CFG_W-1:0] = pin2_high_level_pwm_config;
            ADDR_PIN3_LL: rd_value[CFG_W-1:0] = pin3_low_level_pwm_config;
            ADDR_PIN2_LL: rd_value[CFG_W-1:0] = pin2_low_level_pwm_config;
            ADDR_PIN3_HL: rd_value[CFG_W-1:0] = pin3_high_level_pwm_config;
            ADDR_CTRL: rd_value[CTRL_W-1:0] = level_ctrl;
            ADDR_STATUS: begin
                rd_value[STAT_W-1:0] = {ch3.is_static, ch2.is_static, pin3_out, pin2_out};
                rd_hit = !pwrite;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // answer registered in setup, shown in the first access cycle: no wait states
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable && !pready;
            if (psel && !penable) begin
                prdata <= pwrite ? '0 : rd_value;
                pslverr <= !rd_hit;
            end
        end
    end

    // configuration registers; reserved bits are never stored so read zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin2_high_level_pwm_config <= RST_HIGH_LEVEL;
            pin3_low_level_pwm_config <= RST_LOW_LEVEL;
            pin2_low_level_pwm_config <= RST_LOW_LEVEL;
            pin3_high_level_pwm_config <= RST_HIGH_LEVEL;
        end else if (wr_en) begin
            case (paddr)
                ADDR_PIN2_HL: pin2_high_level_pwm_config <= merge(pin2_high_level_pwm_config,
                                                                  pwdata, pstrb, WMASK_HL);
                ADDR_PIN3_LL: pin3_low_level_pwm_config <= merge(pin3_low_level_pwm_config,
                                                                 pwdata, pstrb, WMASK_LL);
                ADDR_PIN2_LL: pin2_low_level_pwm_config <= merge(pin2_low_level_pwm_config,
                                                                 pwdata, pstrb, WMASK_LL);
                ADDR_PIN3_HL: pin3_high_level_pwm_config <= merge(pin3_high_level_pwm_config,
                                                                  pwdata, pstrb, WMASK_HL);
                default: ;
            endcase
        end
    end

    // level request and pin2 time base
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level_ctrl <= RST_CTRL;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            level_ctrl <= CTRL_W'(merge(CFG_W'(level_ctrl), pwdata, pstrb, WMASK_CTRL));
        end
    end

    // ------------------------------------------------------------
    // level to counter pair selection
    // ------------------------------------------------------------
    assign pin2_level = level_ctrl[CTRL_P2_LEVEL];
    assign pin3_level = level_ctrl[CTRL_P3_LEVEL];
    assign pin2_time_base_select = level_ctrl[CTRL_P2_TB_MSB:CTRL_P2_TB_LSB];
    assign pin3_time_base_select = pin3_low_level_pwm_config[TB_MSB:TB_LSB];

    // restart a pin's wave one cycle after anything it depends on is written,
    // which is the cycle the new value is visible; level changes go through ctrl
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            restart2 <= 1'b0;
            restart3 <= 1'b0;
        end else begin
            restart2 <= wr_en && (paddr == ADDR_PIN2_HL || paddr == ADDR_PIN2_LL
                                  || paddr == ADDR_CTRL);
            restart3 <= wr_en && (paddr == ADDR_PIN3_HL || paddr == ADDR_PIN3_LL
                                  || paddr == ADDR_CTRL);
        end
    end

    // pin2 pair: counts follow the requested level
    assign ch2.restart = restart2;
    assign ch2.time_base = pin2_time_base_select;
    assign ch2.high_count = pin2_level ? pin2_high_level_pwm_config[HC_MSB:HC_LSB]
                                       : pin2_low_level_pwm_config[HC_MSB:HC_LSB];
    assign ch2.low_count = pin2_level ? pin2_high_level_pwm_config[LC_MSB:LC_LSB]
                                      : pin2_low_level_pwm_config[LC_MSB:LC_LSB];

    // pin3 pair: one time base for both levels
    assign ch3.restart = restart3;
    assign ch3.time_base = pin3_time_base_select;
    assign ch3.high_count = pin3_level ? pin3_high_level_pwm_config[HC_MSB:HC_LSB]
                                       : pin3_low_level_pwm_config[HC_MSB:HC_LSB];
    assign ch3.low_count = pin3_level ? pin3_high_level_pwm_config[LC_MSB:LC_LSB]
                                      : pin3_low_level_pwm_config[LC_MSB:LC_LSB];

    // ------------------------------------------------------------
    // generators and pin outputs
    // ------------------------------------------------------------
    pwm_wave_gen u_gen2 (
        .clock(clock),
        .rst(rst),
        .pair(ch2.gen)
    );

    pwm_wave_gen u_gen3 (
        .clock(clock),
        .rst(rst),
        .pair(ch3.gen)
    );

    // registered pins: one cycle behind the generator, glitch free
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin2_out <= 1'b0;
            pin3_out <= 1'b0;
        end else begin
            pin2_out <= ch2.wave;
            pin3_out <= ch3.wave;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_hc_zero_low: assert property (@(posedge clock) disable iff (rst)
        ch2.high_count == COUNT_ZERO |=> !pin2_out)
        else $error("zero high count did not force low");
    a_lc_zero_high: assert property (@(posedge clock) disable iff (rst)
        (ch3.low_count == COUNT_ZERO && ch3.high_count != COUNT_ZERO) |=> pin3_out)
        else $error("zero low count did not force high");
    a_both_zero_low: assert property (@(posedge clock) disable iff (rst)
        (ch3.low_count == COUNT_ZERO && ch3.high_count == COUNT_ZERO) |=> !pin3_out)
        else $error("both zero counts not low");
    a_level_restart: assert property (@(posedge clock) disable iff (rst)
        $changed(pin2_level) |-> restart2 && restart3)
        else $error("level change without restart");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
        (psel && !penable && !pwrite && paddr == ADDR_PIN2_HL)
        |=> prdata[TB_MSB:TB_LSB] == 2'h0 && (prdata[HC_MSB:HC_LSB] == ch2.high_count
            || !pin2_level))
        else $error("reserved bits not zero");
    a_reset_values: assert property (@(posedge clock) disable iff (rst)
        $past(rst) |-> pin2_high_level_pwm_config == RST_HIGH_LEVEL
            && pin3_low_level_pwm_config == RST_LOW_LEVEL)
        else $error("reset value wrong");
    a_tb_shared: assert property (@(posedge clock) disable iff (rst)
        pin3_level |-> ch3.time_base == pin3_low_level_pwm_config[TB_MSB:TB_LSB])
        else $error("pin3 time base not shared");
    c_pin2_rise: cover property (@(posedge clock) disable iff (rst) $rose(pin2_out));
    c_pin3_rise: cover property (@(posedge clock) disable iff (rst) $rose(pin3_out));
    c_level_switch: cover property (@(posedge clock) disable iff (rst) $changed(pin2_level));
endmodule

/* File: design/pwm_wave_gen.sv */
// one pwm waveform generator with its own time base divider
module pwm_wave_gen
    import pwm_enc_pkg::*;
(
    input wire logic clock, // master clock
    input wire logic rst, // async reset, active high
    pwm_pair_if.gen pair // counts in, waveform out
);
    logic hc_zero;
    logic lc_zero;
    logic is_static;
    logic tick;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] mask;
    logic [COUNT_W-1:0] cnt;
    phase_e state;

    // ------------------------------------------------------------
    // static decode
    // ------------------------------------------------------------
    assign hc_zero = (pair.high_count == COUNT_ZERO);
    assign lc_zero = (pair.low_count == COUNT_ZERO);
    assign is_static = hc_zero || lc_zero;
    assign mask = tb_mask(pair.time_base);
    assign tick = ((div & mask) == mask);

    // time base divider, held at zero so every phase starts on a whole unit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div <= '0;
        end else if (pair.restart || is_static || state == PH_STATIC) begin
            div <= '0;
        end else begin
            div <= div + DIV_W'(1);
        end
    end

    // phase machine counting time base units
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= PH_STATIC;
            cnt <= '0;
        end else if (is_static) begin
            state <= PH_STATIC;
            cnt <= '0;
        end else if (pair.restart || state == PH_STATIC) begin
            state <= PH_HIGH;
            cnt <= '0;
        end else if (tick) begin
            case (state)
                PH_HIGH: begin
                    if (cnt == pair.high_count - COUNT_W'(1)) begin
                        state <= PH_LOW;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + COUNT_W'(1);
                    end
                end
                PH_LOW: begin
                    if (cnt == pair.low_count - COUNT_W'(1)) begin
                        state <= PH_HIGH;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + COUNT_W'(1);
                    end
                end
                default: begin
                    state <= PH_HIGH;
                    cnt <= '0;
                end
            endcase
        end
    end

    // both-zero falls to low since hc_zero wins
    assign pair.wave = is_static ? (!hc_zero && lc_zero) : (state == PH_HIGH);
    assign pair.is_static = is_static;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_high_time: assert property (@(posedge clock) disable iff (rst || pair.restart || is_static)
        (state == PH_HIGH && $past(state) != PH_HIGH && pair.high_count == 7'h02
            && pair.time_base == TB_SEL_16)
        |-> ##31 state == PH_HIGH ##1 state == PH_LOW)
        else $error("high phase length wrong");
    a_low_time: assert property (@(posedge clock) disable iff (rst || pair.restart || is_static)
        (state == PH_LOW && $past(state) == PH_HIGH && pair.low_count == 7'h02
            && pair.time_base == TB_SEL_16)
        |-> ##31 state == PH_LOW ##1 state == PH_HIGH)
        else $error("low phase length wrong");
    a_period_sum: assert property (@(posedge clock) disable iff (rst || pair.restart || is_static)
        (state == PH_HIGH && $past(state) == PH_LOW && pair.high_count == 7'h01
            && pair.low_count == 7'h03 && pair.time_base == TB_SEL_16)
        |-> ##64 (state == PH_HIGH && $past(state) == PH_LOW))
        else $error("pwm period wrong");
    a_tick_spacing: assert property (@(posedge clock) disable iff (rst || pair.restart || is_static)
        (tick && pair.time_base == TB_SEL_64) |=> !tick [*8])
        else $error("time base tick too early");
    c_full_cycle: cover property (@(posedge clock) disable iff (rst)
        state == PH_HIGH ##1 state == PH_LOW);
endmodule

/* File: include/pwm_enc_pkg.sv */
// shared constants and types of the level-to-pwm encoder
package pwm_enc_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int COUNT_W = 7;
    localparam int TB_W = 2;
    localparam int DIV_W = 10;
    localparam int CFG_W = 16;
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;
    localparam int CTRL_W = 4;
    localparam int STAT_W = 4;

    // ------------------------------------------------------------
    // register indices and byte addresses (byte = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PIN2_HL = 8'h54;
    localparam logic [7:0] IDX_PIN3_LL = 8'h55;
    localparam logic [7:0] IDX_CTRL = 8'h60;
    localparam logic [7:0] IDX_PIN2_LL = 8'h61;
    localparam logic [7:0] IDX_PIN3_HL = 8'h62;
    localparam logic [7:0] IDX_STATUS = 8'h63;
    localparam logic [APB_ADDR_W-1:0] ADDR_PIN2_HL = {2'h0, IDX_PIN2_HL, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_PIN3_LL = {2'h0, IDX_PIN3_LL, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_PIN2_LL = {2'h0, IDX_PIN2_LL, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_PIN3_HL = {2'h0, IDX_PIN3_HL, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TB_MSB = 15;
    localparam int TB_LSB = 14;
    localparam int HC_MSB = 13;
    localparam int HC_LSB = 7;
    localparam int LC_MSB = 6;
    localparam int LC_LSB = 0;
    localparam int CTRL_P2_LEVEL = 0;
    localparam int CTRL_P3_LEVEL = 1;
    localparam int CTRL_P2_TB_MSB = 3;
    localparam int CTRL_P2_TB_LSB = 2;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [CFG_W-1:0] RST_HIGH_LEVEL = 16'h3F80;
    localparam logic [CFG_W-1:0] RST_LOW_LEVEL = 16'h007F;
    localparam logic [CTRL_W-1:0] RST_CTRL = 4'h0;
    localparam logic [CFG_W-1:0] WMASK_HL = 16'h3FFF;
    localparam logic [CFG_W-1:0] WMASK_LL = 16'hFFFF;
    localparam logic [CFG_W-1:0] WMASK_CTRL = 16'h000F;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 7'h00;

    // ------------------------------------------------------------
    // time base: master clock periods per code
    // ------------------------------------------------------------
    localparam logic [TB_W-1:0] TB_SEL_16 = 2'h0;
    localparam logic [TB_W-1:0] TB_SEL_64 = 2'h1;
    localparam logic [TB_W-1:0] TB_SEL_256 = 2'h2;
    localparam logic [TB_W-1:0] TB_SEL_1024 = 2'h3;
    localparam int TB_CYC_16 = 16;
    localparam int TB_CYC_64 = 64;
    localparam int TB_CYC_256 = 256;
    localparam int TB_CYC_1024 = 1024;

    typedef enum logic [2:0] {
        PH_STATIC = 3'b001,
        PH_HIGH = 3'b010,
        PH_LOW = 3'b100
    } phase_e;

    // mask whose all-ones pattern marks the last clock of one time base unit
    function automatic logic [DIV_W-1:0] tb_mask(input logic [TB_W-1:0] sel);
        case (sel)
            TB_SEL_16: return DIV_W'(TB_CYC_16 - 1);
            TB_SEL_64: return DIV_W'(TB_CYC_64 - 1);
            TB_SEL_256: return DIV_W'(TB_CYC_256 - 1);
            default: return DIV_W'(TB_CYC_1024 - 1);
        endcase
    endfunction
endpackage

/* File: include/pwm_pair_if.sv */
// carrier between the register block and one waveform generator
interface pwm_pair_if;
    import pwm_enc_pkg::*;
    logic restart;
    logic [TB_W-1:0] time_base;
    logic [COUNT_W-1:0] high_count;
    logic [COUNT_W-1:0] low_count;
    logic wave;
    logic is_static;
    modport ctl(output restart, time_base, high_count, low_count, input wave, is_static);
    modport gen(input restart, time_base, high_count, low_count, output wave, is_static);
endinterface
